// >>> pkg/cpu_slice_pkg.sv
// Constants and types for the bit, flag and load execution slice
package cpu_slice_pkg;
    localparam int REG_COUNT = 32;
    localparam logic [5:0] ADDR_STATUS = 6'h20;
    localparam logic [5:0] ADDR_PC_LO = 6'h21;
    localparam logic [5:0] ADDR_PC_HI = 6'h22;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    localparam logic [1:0] PTR_SEL_X = 2'h0;
    localparam logic [1:0] PTR_SEL_Y = 2'h1;
    typedef enum logic [4:0] {
        op_nop, op_branch_if_int_on, op_branch_if_int_off, op_io_bit_set, op_io_bit_clear,
        op_shift_left_logical, op_shift_right_logical, op_rotate_left_carry,
        op_rotate_right_carry, op_shift_right_arith, op_nibble_swap, op_indexed_flag_set,
        op_indexed_flag_clear, op_copy_bit_to_transfer_flag, op_load_bit_from_transfer_flag,
        op_copy_register, op_copy_register_pair, op_load_immediate, op_indirect_load,
        op_indirect_load_inc, op_indirect_load_dec
    } op_t;
endpackage

// >>> rtl/cpu_bit_flag_load_ops.sv
// Execution unit for branches on I, bit, shift, flag and load operations
//
// Functional notes
// [RL1] Branch when I set: pc plus k plus one
// [RL2] Branch when I clear: pc plus k plus one
// [RL3] Set or clear one I/O bit, two cycles
// [RL4] Logical left shift, zero in, flags updated
// [RL5] Logical right shift, zero in bit seven
// [RL6] Rotate left through carry, one cycle
// [RL7] Rotate right through carry, one cycle
// [RL8] Arithmetic right shift keeps sign bit
// [RL9] Nibble swap, flags unchanged, one cycle
// [RL10] Set or clear any single status flag
// [RL11] Copy register bit into transfer flag
// [RL12] Copy transfer flag into register bit
// [RL13] Indirect load, optional post increment, two cycles
// [RL14] Pre-decrement pointer then load, two cycles
// [RL15] Copies and immediate load leave flags alone
// [RL16] Shift zero from result, negative from bit seven
`timescale 1ns/1ps
module cpu_bit_flag_load_ops (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic issue_i,
    input wire cpu_slice_pkg::op_t op_i,
    input wire logic [4:0] rd_i,
    input wire logic [4:0] rr_i,
    input wire logic [2:0] bit_i,
    input wire logic [6:0] k_i,
    input wire logic [7:0] imm_i,
    input wire logic [1:0] ptr_i,
    input wire logic [5:0] io_addr_i,
    output logic ready_o,
    output logic done_o,
    output logic [15:0] pc_o,
    output logic [7:0] flags_o,
    output logic [5:0] io_addr_o,
    output logic [2:0] io_bit_o,
    output logic io_set_o,
    output logic io_clr_o,
    output logic [15:0] dmem_addr_o,
    output logic dmem_rd_o,
    input wire logic [7:0] dmem_rdata_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);
    typedef enum {st_exec, st_refill, st_io, st_load} state_t;

    state_t state_q, state_d;
    logic [7:0] regs_q [cpu_slice_pkg::REG_COUNT];
    logic [7:0] regs_d [cpu_slice_pkg::REG_COUNT];
    logic [15:0] pc_q, pc_d;
    logic [7:0] flags_q, flags_d;
    logic done_q, done_d;
    logic [5:0] io_addr_q, io_addr_d;
    logic [2:0] io_bit_q, io_bit_d;
    logic io_set_q, io_set_d, io_clr_q, io_clr_d;
    logic [15:0] dmem_addr_q, dmem_addr_d;
    logic dmem_rd_q, dmem_rd_d;
    logic [4:0] ld_rd_q, ld_rd_d;
    logic [7:0] reg_rdata_q, reg_rdata_d;
    logic [7:0] opa;
    logic [8:0] shres;
    logic [15:0] k_ext, ptr_val;
    logic [4:0] ptr_lo;
    logic go;

    // Shift and rotate result with carry out in the top bit
    function automatic logic [8:0] shift_op(input cpu_slice_pkg::op_t op, input logic [7:0] a,
                                            input logic cin);
        logic [8:0] r;
        r = {1'b0, a};
        unique case (op)
            cpu_slice_pkg::op_shift_left_logical: r = {a[7], a[6:0], 1'b0}; // see [RL4]
            cpu_slice_pkg::op_shift_right_logical: r = {a[0], 1'b0, a[7:1]}; // see [RL5]
            cpu_slice_pkg::op_rotate_left_carry: r = {a[7], a[6:0], cin}; // see [RL6]
            cpu_slice_pkg::op_rotate_right_carry: r = {a[0], cin, a[7:1]}; // see [RL7]
            cpu_slice_pkg::op_shift_right_arith: r = {a[0], a[7], a[7:1]}; // see [RL8]
            default: r = {1'b0, a};
        endcase
        return r;
    endfunction

    // Low register index of the selected pointer pair
    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        logic [4:0] b;
        b = cpu_slice_pkg::PTR_Z_LO;
        if (sel == cpu_slice_pkg::PTR_SEL_X) begin
            b = cpu_slice_pkg::PTR_X_LO;
        end else if (sel == cpu_slice_pkg::PTR_SEL_Y) begin
            b = cpu_slice_pkg::PTR_Y_LO;
        end
        return b;
    endfunction

    assign go = issue_i && (state_q == st_exec);
    assign opa = regs_q[rd_i];
    assign shres = shift_op(op_i, opa, flags_q[cpu_slice_pkg::FLAG_C]);
    assign k_ext = {{9{k_i[6]}}, k_i};
    assign ptr_lo = ptr_base(ptr_i);
    assign ptr_val = {regs_q[ptr_lo + 5'h01], regs_q[ptr_lo]};

    always_comb begin
        state_d = state_q;
        regs_d = regs_q;
        pc_d = pc_q;
        flags_d = flags_q;
        done_d = 1'b0;
        io_addr_d = io_addr_q;
        io_bit_d = io_bit_q;
        io_set_d = 1'b0;
        io_clr_d = 1'b0;
        dmem_addr_d = dmem_addr_q;
        dmem_rd_d = 1'b0;
        ld_rd_d = ld_rd_q;
        reg_rdata_d = 8'h00;
        // Register port read
        if (reg_rd_i) begin
            if (!reg_addr_i[5]) begin
                reg_rdata_d = regs_q[reg_addr_i[4:0]];
            end else if (reg_addr_i == cpu_slice_pkg::ADDR_STATUS) begin
                reg_rdata_d = flags_q;
            end else if (reg_addr_i == cpu_slice_pkg::ADDR_PC_LO) begin
                reg_rdata_d = pc_q[7:0];
            end else if (reg_addr_i == cpu_slice_pkg::ADDR_PC_HI) begin
                reg_rdata_d = pc_q[15:8];
            end
        end
        // Register port write, overridden by the core below
        if (reg_wr_i) begin
            if (!reg_addr_i[5]) begin
                regs_d[reg_addr_i[4:0]] = reg_wdata_i;
            end else if (reg_addr_i == cpu_slice_pkg::ADDR_STATUS) begin
                flags_d = reg_wdata_i;
            end else if (reg_addr_i == cpu_slice_pkg::ADDR_PC_LO) begin
                pc_d[7:0] = reg_wdata_i;
            end else if (reg_addr_i == cpu_slice_pkg::ADDR_PC_HI) begin
                pc_d[15:8] = reg_wdata_i;
            end
        end
        unique case (state_q)
            st_exec: begin
                if (issue_i) begin
                    pc_d = pc_q + cpu_slice_pkg::PC_STEP;
                    done_d = 1'b1;
                    unique case (op_i)
                        cpu_slice_pkg::op_nop: begin
                        end
                        cpu_slice_pkg::op_branch_if_int_on,
                        cpu_slice_pkg::op_branch_if_int_off: begin
                            if (flags_q[cpu_slice_pkg::FLAG_I]
                                == (op_i == cpu_slice_pkg::op_branch_if_int_on)) begin
                                pc_d = pc_q + k_ext + cpu_slice_pkg::PC_STEP; // see [RL1] [RL2]
                                state_d = st_refill;
                                done_d = 1'b0;
                            end
                        end
                        cpu_slice_pkg::op_io_bit_set,
                        cpu_slice_pkg::op_io_bit_clear: begin
                            io_addr_d = io_addr_i; // see [RL3]
                            io_bit_d = bit_i;
                            io_set_d = (op_i == cpu_slice_pkg::op_io_bit_set);
                            io_clr_d = (op_i == cpu_slice_pkg::op_io_bit_clear);
                            state_d = st_io;
                            done_d = 1'b0;
                        end
                        cpu_slice_pkg::op_shift_left_logical,
                        cpu_slice_pkg::op_shift_right_logical,
                        cpu_slice_pkg::op_rotate_left_carry,
                        cpu_slice_pkg::op_rotate_right_carry,
                        cpu_slice_pkg::op_shift_right_arith: begin
                            regs_d[rd_i] = shres[7:0];
                            flags_d[cpu_slice_pkg::FLAG_C] = shres[8];
                            flags_d[cpu_slice_pkg::FLAG_Z] = (shres[7:0] == 8'h00); // see [RL16]
                            flags_d[cpu_slice_pkg::FLAG_N] = shres[7]; // see [RL16]
                            flags_d[cpu_slice_pkg::FLAG_V] = shres[7] ^ shres[8];
                        end
                        cpu_slice_pkg::op_nibble_swap: begin
                            regs_d[rd_i] = {opa[3:0], opa[7:4]}; // see [RL9]
                        end
                        cpu_slice_pkg::op_indexed_flag_set: begin
                            flags_d[bit_i] = 1'b1; // see [RL10]
                        end
                        cpu_slice_pkg::op_indexed_flag_clear: begin
                            flags_d[bit_i] = 1'b0; // see [RL10]
                        end
                        cpu_slice_pkg::op_copy_bit_to_transfer_flag: begin
                            flags_d[cpu_slice_pkg::FLAG_T] = regs_q[rr_i][bit_i]; // see [RL11]
                        end
                        cpu_slice_pkg::op_load_bit_from_transfer_flag: begin
                            regs_d[rd_i][bit_i] = flags_q[cpu_slice_pkg::FLAG_T]; // see [RL12]
                        end
                        cpu_slice_pkg::op_copy_register: begin
                            regs_d[rd_i] = regs_q[rr_i]; // see [RL15]
                        end
                        cpu_slice_pkg::op_copy_register_pair: begin
                            regs_d[{rd_i[4:1], 1'b0}] = regs_q[{rr_i[4:1], 1'b0}]; // see [RL15]
                            regs_d[{rd_i[4:1], 1'b1}] = regs_q[{rr_i[4:1], 1'b1}];
                        end
                        cpu_slice_pkg::op_load_immediate: begin
                            regs_d[rd_i] = imm_i; // see [RL15]
                        end
                        cpu_slice_pkg::op_indirect_load, cpu_slice_pkg::op_indirect_load_inc,
                        cpu_slice_pkg::op_indirect_load_dec: begin
                            dmem_addr_d = ptr_val; // see [RL13]
                            if (op_i == cpu_slice_pkg::op_indirect_load_dec) begin
                                dmem_addr_d = ptr_val - cpu_slice_pkg::PC_STEP; // see [RL14]
                                {regs_d[ptr_lo + 5'h01], regs_d[ptr_lo]} = dmem_addr_d;
                            end else if (op_i == cpu_slice_pkg::op_indirect_load_inc) begin
                                {regs_d[ptr_lo + 5'h01], regs_d[ptr_lo]} =
                                    ptr_val + cpu_slice_pkg::PC_STEP; // see [RL13]
                            end
                            dmem_rd_d = 1'b1;
                            ld_rd_d = rd_i;
                            state_d = st_load;
                            done_d = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            st_refill, st_io: begin
                state_d = st_exec;
                done_d = 1'b1;
            end
            st_load: begin
                regs_d[ld_rd_q] = dmem_rdata_i; // see [RL13] [RL14]
                state_d = st_exec;
                done_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= st_exec;
            regs_q <= '{default: cpu_slice_pkg::REG_RESET};
            pc_q <= cpu_slice_pkg::PC_RESET;
            flags_q <= cpu_slice_pkg::STATUS_RESET;
            done_q <= 1'b0;
            io_addr_q <= 6'h00;
            io_bit_q <= 3'h0;
            io_set_q <= 1'b0;
            io_clr_q <= 1'b0;
            dmem_addr_q <= 16'h0000;
            dmem_rd_q <= 1'b0;
            ld_rd_q <= 5'h00;
            reg_rdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            regs_q <= regs_d;
            pc_q <= pc_d;
            flags_q <= flags_d;
            done_q <= done_d;
            io_addr_q <= io_addr_d;
            io_bit_q <= io_bit_d;
            io_set_q <= io_set_d;
            io_clr_q <= io_clr_d;
            dmem_addr_q <= dmem_addr_d;
            dmem_rd_q <= dmem_rd_d;
            ld_rd_q <= ld_rd_d;
            reg_rdata_q <= reg_rdata_d;
        end
    end

    assign ready_o = (state_q == st_exec);
    assign done_o = done_q;
    assign pc_o = pc_q;
    assign flags_o = flags_q;
    assign io_addr_o = io_addr_q;
    assign io_bit_o = io_bit_q;
    assign io_set_o = io_set_q;
    assign io_clr_o = io_clr_q;
    assign dmem_addr_o = dmem_addr_q;
    assign dmem_rd_o = dmem_rd_q;
    assign reg_rdata_o = reg_rdata_q;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic opa7, opa0, opa_bit, cflag, tflag;
    assign opa7 = opa[7];
    assign opa0 = opa[0];
    assign opa_bit = regs_q[rr_i][bit_i];
    assign cflag = flags_q[cpu_slice_pkg::FLAG_C];
    assign tflag = flags_q[cpu_slice_pkg::FLAG_T];

    property p_br_on;
        go && op_i == cpu_slice_pkg::op_branch_if_int_on && flags_q[cpu_slice_pkg::FLAG_I]
        |=> pc_q == $past(pc_q) + $past(k_ext) + 16'h0001 && !ready_o ##1 ready_o;
    endproperty
    a_br_on: assert property (p_br_on) else $error("taken branch on I wrong"); // see [RL1]
    property p_br_off;
        go && op_i == cpu_slice_pkg::op_branch_if_int_off && flags_q[cpu_slice_pkg::FLAG_I]
        |=> pc_q == $past(pc_q) + 16'h0001 && ready_o && done_o;
    endproperty
    a_br_off: assert property (p_br_off) else $error("untaken branch wrong"); // see [RL2]
    property p_io;
        go && op_i == cpu_slice_pkg::op_io_bit_set |=> io_set_o && !io_clr_o
        && io_addr_o == $past(io_addr_i) && flags_q == $past(flags_q) ##1 !io_set_o && ready_o;
    endproperty
    a_io: assert property (p_io) else $error("io bit set sequence wrong"); // see [RL3]
    property p_lsl;
        go && op_i == cpu_slice_pkg::op_shift_left_logical
        |=> cflag == $past(opa7) && regs_q[$past(rd_i)][0] == 1'b0;
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong"); // see [RL4]
    property p_lsr;
        go && op_i == cpu_slice_pkg::op_shift_right_logical
        |=> cflag == $past(opa0) && !flags_q[cpu_slice_pkg::FLAG_N] && !regs_q[$past(rd_i)][7];
    endproperty
    a_lsr: assert property (p_lsr) else $error("right shift wrong"); // see [RL5]
    property p_rol;
        go && op_i == cpu_slice_pkg::op_rotate_left_carry
        |=> regs_q[$past(rd_i)][0] == $past(cflag) && cflag == $past(opa7);
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong"); // see [RL6]
    property p_ror;
        go && op_i == cpu_slice_pkg::op_rotate_right_carry
        |=> regs_q[$past(rd_i)][7] == $past(cflag) && cflag == $past(opa0);
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right wrong"); // see [RL7]
    property p_asr;
        go && op_i == cpu_slice_pkg::op_shift_right_arith
        |=> regs_q[$past(rd_i)][7] == $past(opa7);
    endproperty
    a_asr: assert property (p_asr) else $error("sign bit lost"); // see [RL8]
    property p_swap;
        go && op_i == cpu_slice_pkg::op_nibble_swap |=> flags_q == $past(flags_q) && ready_o;
    endproperty
    a_swap: assert property (p_swap) else $error("swap touched flags"); // see [RL9]
    property p_fset;
        go && op_i == cpu_slice_pkg::op_indexed_flag_set |=> flags_q[$past(bit_i)] && done_o;
    endproperty
    a_fset: assert property (p_fset) else $error("flag not set"); // see [RL10]
    property p_bst;
        go && op_i == cpu_slice_pkg::op_copy_bit_to_transfer_flag |=> tflag == $past(opa_bit);
    endproperty
    a_bst: assert property (p_bst) else $error("transfer flag copy wrong"); // see [RL11]
    property p_bld;
        go && op_i == cpu_slice_pkg::op_load_bit_from_transfer_flag
        |=> regs_q[$past(rd_i)][$past(bit_i)] == $past(tflag) && flags_q == $past(flags_q);
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrong"); // see [RL12]
    property p_ld_inc;
        go && op_i == cpu_slice_pkg::op_indirect_load_inc
        |=> dmem_rd_o && dmem_addr_o == $past(ptr_val) && !done_o ##1 done_o && ready_o;
    endproperty
    a_ld_inc: assert property (p_ld_inc) else $error("post increment load wrong"); // see [RL13]
    property p_ld_dec;
        go && op_i == cpu_slice_pkg::op_indirect_load_dec
        |=> dmem_addr_o == $past(ptr_val) - 16'h0001 && flags_q == $past(flags_q);
    endproperty
    a_ld_dec: assert property (p_ld_dec) else $error("pre decrement load wrong"); // see [RL14]
    property p_imm;
        go && op_i == cpu_slice_pkg::op_load_immediate && !reg_wr_i
        |=> regs_q[$past(rd_i)] == $past(imm_i) && flags_q == $past(flags_q);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate load wrong"); // see [RL15]
    property p_zero;
        go && op_i == cpu_slice_pkg::op_shift_left_logical
        |=> flags_q[cpu_slice_pkg::FLAG_Z] == (regs_q[$past(rd_i)] == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong"); // see [RL16]
    c_branch: cover property (go && op_i == cpu_slice_pkg::op_branch_if_int_on ##1 !ready_o);
    c_io_clr: cover property (io_clr_o);
    c_load: cover property (dmem_rd_o ##1 done_o);
    c_shift_zero: cover property (go && op_i == cpu_slice_pkg::op_shift_right_logical
        && opa == 8'h01);
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the bit, flag and load execution slice
`timescale 1ns/1ps
module testbench;
    logic mclk_i, rst_i, issue_i, reg_wr_i, reg_rd_i;
    cpu_slice_pkg::op_t op_i;
    logic [4:0] rd_i, rr_i;
    logic [2:0] bit_i, io_bit_o;
    logic [6:0] k_i;
    logic [7:0] imm_i, flags_o, dmem_rdata_i, reg_wdata_i, reg_rdata_o;
    logic [1:0] ptr_i;
    logic [5:0] io_addr_i, io_addr_o, reg_addr_i;
    logic ready_o, done_o, io_set_o, io_clr_o, dmem_rd_o;
    logic [15:0] pc_o, dmem_addr_o;
    logic [7:0] m_reg [32];
    logic [7:0] m_flags;
    logic [15:0] m_pc;
    logic [31:0] seed;
    int errors, compares;

    cpu_bit_flag_load_ops cpu_bit_flag_load_ops_i (.mclk_i, .rst_i, .issue_i, .op_i, .rd_i,
        .rr_i, .bit_i, .k_i, .imm_i, .ptr_i, .io_addr_i, .ready_o, .done_o, .pc_o, .flags_o,
        .io_addr_o, .io_bit_o, .io_set_o, .io_clr_o, .dmem_addr_o, .dmem_rd_o, .dmem_rdata_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);

    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Data memory answers in the same cycle
    assign dmem_rdata_i = mem(dmem_addr_o);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic check_all();
        logic [7:0] v;
        for (int i = 0; i < 32; i++) begin
            rd(6'(i), v);
            chk(16'(v), 16'(m_reg[i]), "register");
        end
        rd(cpu_slice_pkg::ADDR_STATUS, v);
        chk(16'(v), 16'(m_flags), "status");
        rd(cpu_slice_pkg::ADDR_PC_LO, v);
        chk(16'(v), 16'(m_pc[7:0]), "pc low");
        rd(cpu_slice_pkg::ADDR_PC_HI, v);
        chk(16'(v), 16'(m_pc[15:8]), "pc high");
        rd(6'h30, v);
        chk(16'(v), 16'h0000, "unmapped");
    endtask

    task automatic exec(input cpu_slice_pkg::op_t op, input logic [4:0] d, input logic [4:0] r,
            input logic [2:0] b, input logic [6:0] k, input logic [7:0] imm,
            input logic [1:0] ptr, input logic [5:0] io);
        int n, ecyc;
        logic [7:0] o, v;
        logic [15:0] p, ea;
        logic [4:0] pl;
        logic c, ld;
        ecyc = 1;
        ld = 1'b0;
        o = m_reg[d];
        c = m_flags[cpu_slice_pkg::FLAG_C];
        v = o;
        m_pc = m_pc + cpu_slice_pkg::PC_STEP;
        pl = ptr[1] ? cpu_slice_pkg::PTR_Z_LO :
            (ptr[0] ? cpu_slice_pkg::PTR_Y_LO : cpu_slice_pkg::PTR_X_LO);
        p = {m_reg[pl + 5'h01], m_reg[pl]};
        ea = (op == cpu_slice_pkg::op_indirect_load_dec) ? p - 16'h0001 : p;
        case (op)
            cpu_slice_pkg::op_branch_if_int_on, cpu_slice_pkg::op_branch_if_int_off: begin
                if (m_flags[cpu_slice_pkg::FLAG_I]
                    == (op == cpu_slice_pkg::op_branch_if_int_on)) begin
                    m_pc = m_pc + {{9{k[6]}}, k};
                    ecyc = 2;
                end
            end
            cpu_slice_pkg::op_io_bit_set, cpu_slice_pkg::op_io_bit_clear: ecyc = 2;
            cpu_slice_pkg::op_shift_left_logical: {c, v} = {o, 1'b0};
            cpu_slice_pkg::op_shift_right_logical: {v, c} = {1'b0, o};
            cpu_slice_pkg::op_rotate_left_carry: {c, v} = {o, c};
            cpu_slice_pkg::op_rotate_right_carry: {v, c} = {c, o};
            cpu_slice_pkg::op_shift_right_arith: {v, c} = {o[7], o};
            cpu_slice_pkg::op_nibble_swap: m_reg[d] = {o[3:0], o[7:4]};
            cpu_slice_pkg::op_indexed_flag_set: m_flags[b] = 1'b1;
            cpu_slice_pkg::op_indexed_flag_clear: m_flags[b] = 1'b0;
            cpu_slice_pkg::op_copy_bit_to_transfer_flag:
                m_flags[cpu_slice_pkg::FLAG_T] = m_reg[r][b];
            cpu_slice_pkg::op_load_bit_from_transfer_flag:
                m_reg[d][b] = m_flags[cpu_slice_pkg::FLAG_T];
            cpu_slice_pkg::op_copy_register: m_reg[d] = m_reg[r];
            cpu_slice_pkg::op_copy_register_pair: begin
                m_reg[{d[4:1], 1'b0}] = m_reg[{r[4:1], 1'b0}];
                m_reg[{d[4:1], 1'b1}] = m_reg[{r[4:1], 1'b1}];
            end
            cpu_slice_pkg::op_load_immediate: m_reg[d] = imm;
            cpu_slice_pkg::op_indirect_load, cpu_slice_pkg::op_indirect_load_inc,
            cpu_slice_pkg::op_indirect_load_dec: begin
                ld = 1'b1;
                ecyc = 2;
                if (op == cpu_slice_pkg::op_indirect_load_inc) begin
                    {m_reg[pl + 5'h01], m_reg[pl]} = p + 16'h0001;
                end
                if (op == cpu_slice_pkg::op_indirect_load_dec) begin
                    {m_reg[pl + 5'h01], m_reg[pl]} = ea;
                end
                m_reg[d] = mem(ea);
            end
            default: ;
        endcase
        if (op >= cpu_slice_pkg::op_shift_left_logical
            && op <= cpu_slice_pkg::op_shift_right_arith) begin
            m_reg[d] = v;
            m_flags[cpu_slice_pkg::FLAG_C] = c;
            m_flags[cpu_slice_pkg::FLAG_Z] = (v == 8'h00);
            m_flags[cpu_slice_pkg::FLAG_N] = v[7];
            m_flags[cpu_slice_pkg::FLAG_V] = v[7] ^ c;
        end
        @(posedge mclk_i);
        issue_i <= 1'b1;
        op_i <= op;
        {rd_i, rr_i, bit_i, k_i, imm_i, ptr_i, io_addr_i} <= {d, r, b, k, imm, ptr, io};
        @(posedge mclk_i);
        issue_i <= 1'b0;
        #1;
        chk(16'(ready_o), 16'(ecyc == 1), "ready");
        chk(16'(io_set_o), 16'(op == cpu_slice_pkg::op_io_bit_set), "io set");
        chk(16'(io_clr_o), 16'(op == cpu_slice_pkg::op_io_bit_clear), "io clear");
        if (io_set_o === 1'b1 || io_clr_o === 1'b1) begin
            chk({7'h00, io_bit_o, io_addr_o}, {7'h00, b, io}, "io target");
        end
        chk(16'(dmem_rd_o), 16'(ld), "load strobe");
        if (ld) begin
            chk(dmem_addr_o, ea, "load address");
        end
        n = 1;
        while (done_o !== 1'b1 && n < 8) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk(16'(n), 16'(ecyc), "cycles");
        if (done_o !== 1'b1) begin
            finish_test();
        end
        chk(16'(flags_o), 16'(m_flags), "flags");
        chk(pc_o, m_pc, "pc");
        rd({1'b0, d}, v);
        chk(16'(v), 16'(m_reg[d]), "result");
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    initial begin
        {issue_i, reg_wr_i, reg_rd_i, rd_i, rr_i, bit_i, k_i, imm_i, ptr_i, io_addr_i} = '0;
        op_i = cpu_slice_pkg::op_nop;
        reg_addr_i = 6'h00;
        reg_wdata_i = 8'h00;
        seed = 32'hE073B358;
        errors = 0;
        compares = 0;
        rst_i = 1'b1;
        foreach (m_reg[i]) m_reg[i] = cpu_slice_pkg::REG_RESET;
        m_flags = cpu_slice_pkg::STATUS_RESET;
        m_pc = cpu_slice_pkg::PC_RESET;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        check_all();
        $display("test reset values done");
        for (int i = 0; i < 35; i++) begin
            seed = lfsr(seed);
            wr(6'(i), seed[7:0]);
            if (i < 32) m_reg[i] = seed[7:0];
            else if (i == 32) m_flags = seed[7:0];
            else if (i == 33) m_pc[7:0] = seed[7:0];
            else m_pc[15:8] = seed[7:0];
        end
        wr(6'h30, 8'hFF);
        check_all();
        $display("test register port done");
        for (int i = 0; i < 4; i++) begin
            exec(i[0] ? cpu_slice_pkg::op_indexed_flag_set : cpu_slice_pkg::op_indexed_flag_clear,
                5'h00, 5'h00, 3'h7, 7'h00, 8'h00, 2'h0, 6'h00);
            exec(i[1] ? cpu_slice_pkg::op_branch_if_int_on : cpu_slice_pkg::op_branch_if_int_off,
                5'h00, 5'h00, 3'h0, i[0] ? 7'h40 : 7'h3F, 8'h00, 2'h0, 6'h00);
        end
        $display("test branches done");
        repeat (400) begin
            seed = lfsr(seed);
            exec(cpu_slice_pkg::op_t'(5'h01 + seed[4:0] % 5'h14), seed[9:5], seed[14:10],
                seed[17:15], seed[24:18], seed[31:24], seed[26:25], seed[30:25]);
        end
        check_all();
        $display("test random operations done");
        finish_test();
    end
endmodule
